// File: verilog/t1c_pkg.sv
package t1c_pkg;

  // ********************************************
  // Register map and field layout
  // ********************************************
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 8;
  localparam logic [7:0]  ADDR_CONTROL     = 8'h88;
  localparam logic [7:0]  ADDR_MODE        = 8'h89;
  localparam logic [7:0]  ADDR_COUNT_LOW   = 8'h8A;
  localparam logic [7:0]  ADDR_COUNT_HIGH  = 8'h8B;
  localparam logic [7:0]  RESET_CONTROL    = 8'h00;
  localparam logic [7:0]  RESET_MODE       = 8'h00;
  localparam logic [7:0]  RESET_COUNT      = 8'h00;
  localparam int          CTRL_FLAG_BIT    = 7;
  localparam int          CTRL_RUN_BIT     = 6;
  localparam int          MODE_FIELD_LSB   = 4;
  localparam logic [4:0]  PRESCALE_MAX     = 5'h1F;
  localparam logic [7:0]  BYTE_MAX         = 8'hFF;

  // ********************************************
  // Timing
  // ********************************************
  localparam int          CLK_PERIOD_NS    = 4;
  localparam int          PERIPH_DIV       = 12;

  typedef enum logic [1:0] {
    T1C_MODE_13BIT  = 2'b00,
    T1C_MODE_16BIT  = 2'b01,
    T1C_MODE_RELOAD = 2'b10,
    T1C_MODE_HALT   = 2'b11
  } t1c_mode_t;

  typedef struct packed {
    logic      gate_select;
    logic      counter_select;
    t1c_mode_t mode;
  } t1c_mode_field_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } t1c_bus_req_t;

  typedef struct packed {
    logic split_mode;
    logic split_overflow;
    logic int_ack;
  } t1c_partner_t;

  function automatic t1c_mode_field_t t1c_decode_mode(input logic [7:0] mode_reg);
    t1c_decode_mode = t1c_mode_field_t'(mode_reg[MODE_FIELD_LSB +: 4]);
  endfunction

endpackage

// File: verilog/t1c_tick_gen.sv
module t1c_tick_gen #(
  parameter int DIV = t1c_pkg::PERIPH_DIV
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  output logic      tick
);
  import t1c_pkg::*;

  localparam int CW = $clog2(DIV);

  logic [CW-1:0] count;

  // ********************************************
  // Peripheral cycle divider
  // ********************************************
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
    end else if (count == CW'(DIV - 1)) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick <= 1'b0;
    end else begin
      tick <= (count == CW'(DIV - 1));
    end
  end

endmodule // t1c_tick_gen

// File: verilog/t1c_fall_sampler.sv
module t1c_fall_sampler (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic tick,
  input  wire logic pin,
  output logic      fall
);
  import t1c_pkg::*;

  logic sample_now;

  // ********************************************
  // One sample per peripheral cycle
  // ********************************************
  // Reset low so the first sample after reset never looks like a fall
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sample_now <= 1'b0;
    end else if (tick) begin
      sample_now <= pin;
    end
  end

  // High sample then low sample gives one event, held for a single clock
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fall <= 1'b0;
    end else begin
      fall <= tick & sample_now & ~pin;
    end
  end

endmodule // t1c_fall_sampler

// File: verilog/t1c_timer.sv
module t1c_timer #(
  parameter int PERIPH_DIV = t1c_pkg::PERIPH_DIV
) (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire t1c_pkg::t1c_bus_req_t bus_req,
  output logic [t1c_pkg::DATA_W-1:0] bus_rdata,
  input  wire logic                 event_input_pin,
  input  wire logic                 external_gate_pin,
  input  wire t1c_pkg::t1c_partner_t partner,
  output logic                      overflow_flag,
  output logic                      irq_request,
  output logic                      overflow_pulse,
  output logic                      run_to_partner
);
  import t1c_pkg::*;

  // ********************************************
  // Declarations
  // ********************************************
  logic [7:0]      timer_mode_register;
  logic [7:0]      timer_control_register;
  logic [7:0]      count_low_byte;
  logic [7:0]      count_high_byte;
  logic            run_control_bit;
  logic            flag;

  t1c_mode_field_t mode_field;
  logic            periph_tick;
  logic            event_fall;
  logic            count_source;
  logic            gate_open;
  logic            run_effective;
  logic            count_step;

  logic            wr_control;
  logic            wr_mode;
  logic            wr_low;
  logic            wr_high;

  logic [7:0]      next_low;
  logic [7:0]      next_high;
  logic            next_overflow;

  // ********************************************
  // Peripheral cycle and event sampling
  // ********************************************
  t1c_tick_gen #(
    .DIV (PERIPH_DIV)
  ) u_tick (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .tick     (periph_tick)
  );

  t1c_fall_sampler u_fall (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .tick     (periph_tick),
    .pin      (event_input_pin),
    .fall     (event_fall)
  );

  // ********************************************
  // Write decode
  // ********************************************
  always_comb begin
    wr_control = bus_req.wr && (bus_req.addr == ADDR_CONTROL);
    wr_mode    = bus_req.wr && (bus_req.addr == ADDR_MODE);
    wr_low     = bus_req.wr && (bus_req.addr == ADDR_COUNT_LOW);
    wr_high    = bus_req.wr && (bus_req.addr == ADDR_COUNT_HIGH);
  end

  // ********************************************
  // Mode register
  // ********************************************
  // The lower nibble belongs to the other timer; it is kept so that
  // software reads back what it wrote.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_mode_register <= RESET_MODE;
    end else if (wr_mode) begin
      timer_mode_register <= bus_req.wdata;
    end
  end

  assign mode_field = t1c_decode_mode(timer_mode_register);

  // ********************************************
  // Control register
  // ********************************************
  // Bits other than run and flag belong to neighbouring logic and are
  // only stored here.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_control_register <= RESET_CONTROL;
    end else if (wr_control) begin
      timer_control_register <= bus_req.wdata;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_control_bit <= 1'b0;
    end else if (wr_control) begin
      run_control_bit <= bus_req.wdata[CTRL_RUN_BIT];
    end
  end

  // ********************************************
  // Count enable
  // ********************************************
  always_comb begin
    // Timer operation counts peripheral cycles, counter operation counts
    // falling edges of the event pin
    count_source = mode_field.counter_select ? event_fall : periph_tick;
    // Gate pin only matters when gating is selected; low pauses counting
    gate_open = ~mode_field.gate_select | external_gate_pin;
    // In split mode the other timer owns the run bit, so this timer
    // free-runs and software stops it by selecting the halt mode
    run_effective = partner.split_mode ? 1'b1 : run_control_bit;
    count_step = count_source & gate_open & run_effective &
                 (mode_field.mode != T1C_MODE_HALT);
  end

  // ********************************************
  // Next count
  // ********************************************
  always_comb begin
    next_low      = count_low_byte;
    next_high     = count_high_byte;
    next_overflow = 1'b0;
    if (count_step) begin
      unique case (mode_field.mode)
        T1C_MODE_13BIT: begin
          // Upper three low bits stay as they are
          next_low[4:0] = count_low_byte[4:0] + 5'h01;
          if (count_low_byte[4:0] == PRESCALE_MAX) begin
            next_high = count_high_byte + 8'h01;
            next_overflow = (count_high_byte == BYTE_MAX);
          end
        end
        T1C_MODE_16BIT: begin
          next_low = count_low_byte + 8'h01;
          if (count_low_byte == BYTE_MAX) begin
            next_high = count_high_byte + 8'h01;
            next_overflow = (count_high_byte == BYTE_MAX);
          end
        end
        T1C_MODE_RELOAD: begin
          if (count_low_byte == BYTE_MAX) begin
            next_low      = count_high_byte;
            next_overflow = 1'b1;
          end else begin
            next_low = count_low_byte + 8'h01;
          end
        end
        T1C_MODE_HALT: begin
          next_low  = count_low_byte;
          next_high = count_high_byte;
        end
      endcase
    end
  end

  // ********************************************
  // Count bytes
  // ********************************************
  // A software write to a count byte wins over a step in the same cycle.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_low_byte <= RESET_COUNT;
    end else if (wr_low) begin
      count_low_byte <= bus_req.wdata;
    end else begin
      count_low_byte <= next_low;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_high_byte <= RESET_COUNT;
    end else if (wr_high) begin
      count_high_byte <= bus_req.wdata;
    end else begin
      count_high_byte <= next_high;
    end
  end

  // ********************************************
  // Overflow flag
  // ********************************************
  // Set wins over both the software clear and the vectoring clear, so an
  // overflow in the clearing cycle is never lost.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag <= 1'b0;
    end else if (partner.split_mode ? partner.split_overflow : next_overflow) begin
      flag <= 1'b1;
    end else if (partner.int_ack) begin
      flag <= 1'b0;
    end else if (wr_control) begin
      flag <= bus_req.wdata[CTRL_FLAG_BIT];
    end
  end

  // ********************************************
  // Outputs
  // ********************************************
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      overflow_flag <= 1'b0;
      irq_request   <= 1'b0;
    end else begin
      overflow_flag <= flag;
      irq_request   <= flag;
    end
  end

  // Overflows still clock the serial port while the partner holds the flag
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      overflow_pulse <= 1'b0;
    end else begin
      overflow_pulse <= next_overflow;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_to_partner <= 1'b0;
    end else begin
      run_to_partner <= run_control_bit;
    end
  end

  // ********************************************
  // Read port
  // ********************************************
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_rdata <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_CONTROL: begin
          bus_rdata <= {flag, run_control_bit, timer_control_register[5:0]};
        end
        ADDR_MODE: begin
          bus_rdata <= timer_mode_register;
        end
        ADDR_COUNT_LOW: begin
          bus_rdata <= count_low_byte;
        end
        ADDR_COUNT_HIGH: begin
          bus_rdata <= count_high_byte;
        end
        default: begin
          bus_rdata <= 8'h00;
        end
      endcase
    end else begin
      bus_rdata <= 8'h00;
    end
  end

endmodule // t1c_timer

// File: testbench/t1c_timer_monitor.sv
module t1c_timer_monitor #(
  parameter int PERIPH_DIV = 12
) (
  input wire logic                       core_clk,
  input wire logic                       sys_rst,
  input wire t1c_pkg::t1c_bus_req_t      bus_req,
  input wire logic [t1c_pkg::DATA_W-1:0] bus_rdata,
  input wire logic                       event_input_pin,
  input wire logic                       external_gate_pin,
  input wire t1c_pkg::t1c_partner_t      partner,
  input wire logic                       overflow_flag,
  input wire logic                       irq_request,
  input wire logic                       overflow_pulse,
  input wire logic                       run_to_partner
);
  timeunit 1ns;
  timeprecision 1ps;
  import t1c_pkg::*;
  logic [3:0] mode_q;
  logic       ctrl_set;
  logic       halt_q;
  logic       gate_low;
  assign ctrl_set = bus_req.wr && bus_req.addr == ADDR_CONTROL && bus_req.wdata[7];
  assign halt_q   = mode_q[1:0] == 2'b11;
  assign gate_low = mode_q[3] && !external_gate_pin;
  // Shadow of the mode nibble: the register itself is not visible here
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= 4'h0;
    end else if (bus_req.wr && bus_req.addr == ADDR_MODE) begin
      mode_q <= bus_req.wdata[7:4];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ****
  // Checks; a step sampled at one edge shows as a pulse at the next, the flag one later
  // ****
  sequence ctrl_wr;
    bus_req.wr && bus_req.addr == ADDR_CONTROL;
  endsequence
  sequence ack_alone;
    partner.int_ack && !partner.split_overflow && !ctrl_set;
  endsequence
  irq_follow_a: assert property (irq_request == overflow_flag)
    else $error("irq differs from flag");
  pulse_once_a: assert property (overflow_pulse |=> !overflow_pulse)
    else $error("pulse too long");
  run_copy_a: assert property (ctrl_wr |-> ##2 run_to_partner == $past(bus_req.wdata[6], 2))
    else $error("run copy wrong");
  rd_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == '0)
    else $error("read data outside slot");
  flag_cause_a: assert property ($rose(overflow_flag) |-> $past(overflow_pulse)
    || $past(partner.split_overflow, 2) || $past(ctrl_set, 2)) else $error("flag without cause");
  own_flag_a: assert property (overflow_pulse && !$past(partner.split_mode) |=> overflow_flag)
    else $error("overflow left flag clear");
  ack_clear_a: assert property (ack_alone |-> ##2 (!overflow_flag || $past(overflow_pulse)))
    else $error("ack did not clear flag");
  halt_hold_a: assert property ($past(halt_q) |-> !overflow_pulse)
    else $error("counted while halted");
  gate_low_a: assert property ($past(gate_low) |-> !overflow_pulse)
    else $error("counted with gate low");
  run_off_a: assert property (!run_to_partner && !$past(partner.split_mode)
    |-> !overflow_pulse) else $error("counted with run clear");
endmodule // t1c_timer_monitor

// File: testbench/t1c_pin_model.sv
module t1c_pin_model #(
  parameter int HOLD = 12
) (
  input wire logic core_clk,
  output logic     event_input_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idles high so no stray edge is seen between bursts
  initial event_input_pin = 1'b1;
  task automatic send(input int n);
    repeat (n) begin
      @(posedge core_clk);
      event_input_pin <= 1'b0;
      repeat (HOLD) @(posedge core_clk);
      event_input_pin <= 1'b1;
      repeat (HOLD) @(posedge core_clk);
    end
  endtask
endmodule // t1c_pin_model

// File: testbench/tb_timer1_counter_four_modes.sv
module tb_timer1_counter_four_modes;
  timeunit 1ns;
  timeprecision 1ps;
  import t1c_pkg::*;
  localparam int DIV = 4;
  logic              core_clk = 1'b0;
  logic              sys_rst = 1'b1;
  t1c_bus_req_t      bus_req = '0;
  t1c_partner_t      partner = '0;
  logic              external_gate_pin = 1'b1;
  logic              event_input_pin;
  logic [DATA_W-1:0] bus_rdata;
  logic              overflow_flag;
  logic              irq_request;
  logic              overflow_pulse;
  logic              run_to_partner;
  logic [7:0]        qe[$];
  logic [7:0]        qa[$];
  logic              rd_seen = 1'b0;
  logic [7:0]        rnd;
  int                seed = 32'h95B6;
  int                mismatches = 0;
  int                cmp_count = 0;
  always #2 core_clk = ~core_clk;
  t1c_timer #(.PERIPH_DIV(DIV)) DUT (.core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .event_input_pin(event_input_pin),
    .external_gate_pin(external_gate_pin), .partner(partner), .overflow_flag(overflow_flag),
    .irq_request(irq_request), .overflow_pulse(overflow_pulse),
    .run_to_partner(run_to_partner));
  t1c_pin_model #(.HOLD(3 * DIV)) pins (.core_clk(core_clk), .event_input_pin(event_input_pin));
  // ****
  // Bus tasks; an idle cycle follows each strobe
  // ****
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic r = 1'b0);
    bus_req <= '{~r, r, a, d};
    @(posedge core_clk);
    bus_req <= '0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    qa.push_back(a);
    qe.push_back(e);
    wr(a, 8'h00, 1'b1);
  endtask
  always @(posedge core_clk) begin
    if (rd_seen) begin
      check($sformatf("reg %h", qa.pop_front()), qe.pop_front(), bus_rdata);
    end
    rd_seen = bus_req.rd;
  end
  task automatic wait_pulse(input logic want, input int lim);
    logic s;
    s = 1'b0;
    for (int n = 0; n < lim && !s; n++) begin
      @(posedge core_clk);
      s = overflow_pulse;
    end
    check("overflow pulse", {7'h00, want}, {7'h00, s});
    if (want && !s) print_verdict();
  endtask
  task automatic run_case(input logic [3:0] m, input logic [7:0] lo, hi, c);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_MODE, {m, 4'($random(seed))});
    wr(ADDR_COUNT_LOW, lo);
    wr(ADDR_COUNT_HIGH, hi);
    wr(ADDR_CONTROL, c);
  endtask
  // Halting by mode leaves the flag alone, unlike a control write
  task automatic finish_ovf(input logic [7:0] lo, hi);
    wr(ADDR_MODE, 8'h30);
    rd(ADDR_COUNT_LOW, lo);
    rd(ADDR_COUNT_HIGH, hi);
    rd(ADDR_CONTROL, 8'hC0);
    check("irq request", 8'h01, {7'h00, irq_request});
    partner.int_ack <= 1'b1;
    @(posedge core_clk);
    partner.int_ack <= 1'b0;
    rd(ADDR_CONTROL, 8'h40);
    check("irq request", 8'h00, {7'h00, irq_request});
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(ADDR_CONTROL, RESET_CONTROL);
    rd(ADDR_MODE, RESET_MODE);
    rd(ADDR_COUNT_LOW, RESET_COUNT);
    rd(ADDR_COUNT_HIGH, RESET_COUNT);
    wr(8'h8C, 8'hA5);
    rd(8'h8C, 8'h00);
    rnd = 8'($random(seed));
    wr(ADDR_MODE, rnd);
    rd(ADDR_MODE, rnd);
    wr(ADDR_CONTROL, rnd & 8'h3F);
    rd(ADDR_CONTROL, rnd & 8'h3F);
    $display("test registers done");
    run_case(4'h1, 8'hFE, 8'hFF, 8'h40);
    wait_pulse(1'b1, 40);
    finish_ovf(8'h00, 8'h00);
    run_case(4'h0, 8'hFE, 8'hFF, 8'h40);
    wait_pulse(1'b1, 40);
    finish_ovf(8'hE0, 8'h00);
    rnd = 8'($random(seed));
    run_case(4'h2, 8'hFE, rnd, 8'h40);
    wait_pulse(1'b1, 40);
    finish_ovf(rnd, rnd);
    $display("test modes done");
    run_case(4'h3, 8'hFF, 8'hFF, 8'h40);
    wait_pulse(1'b0, 60);
    rd(ADDR_COUNT_LOW, 8'hFF);
    run_case(4'h1, 8'hFF, 8'hFF, 8'h00);
    wait_pulse(1'b0, 40);
    external_gate_pin <= 1'b0;
    run_case(4'h9, 8'hFF, 8'hFF, 8'h40);
    wait_pulse(1'b0, 40);
    external_gate_pin <= 1'b1;
    wait_pulse(1'b1, 40);
    finish_ovf(8'h00, 8'h00);
    $display("test halt and gate done");
    run_case(4'h5, 8'hFD, 8'hFF, 8'h40);
    pins.send(2);
    rd(ADDR_COUNT_LOW, 8'hFF);
    fork
      pins.send(1);
      wait_pulse(1'b1, 100);
    join
    finish_ovf(8'h00, 8'h00);
    $display("test counter done");
    partner.split_mode <= 1'b1;
    run_case(4'h1, 8'hFE, 8'hFF, 8'h00);
    wait_pulse(1'b1, 40);
    wr(ADDR_MODE, 8'h30);
    rd(ADDR_CONTROL, 8'h00);
    check("irq request", 8'h00, {7'h00, irq_request});
    partner.split_overflow <= 1'b1;
    @(posedge core_clk);
    partner.split_overflow <= 1'b0;
    rd(ADDR_CONTROL, 8'h80);
    check("irq request", 8'h01, {7'h00, irq_request});
    wr(ADDR_CONTROL, 8'h40);
    partner.split_mode <= 1'b0;
    $display("test split done");
    repeat (3) @(posedge core_clk);
    print_verdict();
  end
endmodule // tb_timer1_counter_four_modes

bind t1c_timer t1c_timer_monitor #(.PERIPH_DIV(PERIPH_DIV)) mon (.core_clk(core_clk),
  .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .event_input_pin(event_input_pin), .external_gate_pin(external_gate_pin),
  .partner(partner), .overflow_flag(overflow_flag), .irq_request(irq_request),
  .overflow_pulse(overflow_pulse), .run_to_partner(run_to_partner));
